/* File: pic_ctrl.v */
// Behaviour
// - Writing one to the global enable bit sets the global interrupt enable.
// - Global enable clears on disable instruction, acknowledge, write of zero, reset or any trap.
// - Three levels exist and level 3 beats level 2, which beats level 1.
// - Within one level a fixed per-source ranking decides, also when all share one level.
// - An enabled watchdog interrupt is always at level 3; reset and traps are not ranked.
// - Sources pulse for one clock and each pulse is caught in a sticky request bit.
// - An acknowledge clears the matching request bit.
// - Software writing zero to a request bit clears that pending request.
// - Watchdog reset select at zero turns a time-out into an interrupt, at one into a reset.
`timescale 1ns/100ps
`include "pic_map.vh"

module pic_ctrl (
  input wire clk, // System clock, 25 MHz
  input wire resetn, // Asynchronous reset, active low
  input wire [`PIC_NSRC-1:0] src_pulse, // One-cycle requests from sources
  input wire wdt_timeout, // One-cycle watchdog time-out pulse
  input wire watchdog_reset_select, // Option bit: 1 reset, 0 interrupt
  input wire gie_wr, // Write strobe for global enable bit
  input wire gie_wdata, // Value written to global enable
  input wire disable_irq_instruction, // Disable instruction executed
  input wire [`PIC_TRAP_W-1:0] trap_code, // Trap taken this cycle
  input wire req_wr, // Write strobe for request register
  input wire [`PIC_NSRC-1:0] req_wdata, // Request register write data
  input wire en_wr, // Write strobe for source enables
  input wire [`PIC_NSRC-1:0] en_wdata, // Source enable write data
  input wire lvl_wr, // Write strobe for source levels
  input wire [2*`PIC_NSRC-1:0] lvl_wdata, // Two bits of level per source
  input wire irq_ack, // Core acknowledges presented request
  output reg global_irq_enable, // Global enable state
  output reg [`PIC_NSRC-1:0] req_status, // Sticky pending requests
  output reg irq_valid, // A request is presented
  output reg [`PIC_IDX_W-1:0] irq_idx, // Index of presented request
  output reg [`PIC_LVL_W-1:0] irq_level, // Level of presented request
  output reg wdt_reset_req // Watchdog time-out demands reset
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [`PIC_NSRC-1:0] src_en_r;
  reg [2*`PIC_NSRC-1:0] src_lvl_r;
  reg [`PIC_NSRC-1:0] src_en_nxt;
  reg [2*`PIC_NSRC-1:0] src_lvl_nxt;
  reg [`PIC_NSRC-1:0] req_nxt;
  reg gie_nxt;
  reg trap_any;
  wire wdt_irq_pulse;
  wire [`PIC_NSRC-1:0] raw_pulse;
  wire ack_taken;
  wire [`PIC_NSRC-1:0] ack_clr;
  wire [`PIC_NSRC-1:0] live;
  wire [`PIC_NSRC-1:0] at_l3;
  wire [`PIC_NSRC-1:0] at_l2;
  wire [`PIC_NSRC-1:0] at_l1;
  wire f3, f2, f1;
  wire [`PIC_IDX_W-1:0] i3, i2, i1;
  wire valid_nxt;
  wire [`PIC_IDX_W-1:0] idx_nxt;
  wire [`PIC_LVL_W-1:0] level_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog time-out routing
  // Time-out becomes an interrupt only when reset select is zero
  assign wdt_irq_pulse = wdt_timeout & ~watchdog_reset_select;
  assign raw_pulse = src_pulse |
    ({{(`PIC_NSRC-1){1'b0}}, wdt_irq_pulse} << `PIC_WDT_SRC);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_reset_req <= wdt_timeout & watchdog_reset_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trap decode: every trap cause drops the global enable
  // Undefined nonzero codes are still taken as traps, the safe side
  always @* begin
    case (trap_code)
      `PIC_TRAP_NONE: trap_any = 1'b0;
      `PIC_TRAP_SW: trap_any = 1'b1;
      `PIC_TRAP_ILLEGAL: trap_any = 1'b1;
      `PIC_TRAP_OSC_FAIL: trap_any = 1'b1;
      `PIC_TRAP_WDOSC_FAIL: trap_any = 1'b1;
      default: trap_any = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration
  // A write replaces the whole field at once
  always @* begin
    src_en_nxt = src_en_r;
    if (en_wr) begin
      src_en_nxt = en_wdata;
    end
  end

  always @* begin
    src_lvl_nxt = src_lvl_r;
    if (lvl_wr) begin
      src_lvl_nxt = lvl_wdata;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_en_r <= `PIC_EN_RST;
      src_lvl_r <= `PIC_LVL_RST;
    end else begin
      src_en_r <= src_en_nxt;
      src_lvl_r <= src_lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request register: new pulses win over any clear in the same cycle
  // An acknowledge only counts while a request is presented
  assign ack_taken = irq_ack & irq_valid;
  assign ack_clr = ack_taken ?
    ({{(`PIC_NSRC-1){1'b0}}, 1'b1} << irq_idx) : {`PIC_NSRC{1'b0}};

  always @* begin
    req_nxt = req_status;
    if (req_wr) begin
      req_nxt = req_nxt & req_wdata;
    end
    req_nxt = req_nxt & ~ack_clr;
    req_nxt = req_nxt | raw_pulse;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_status <= `PIC_REQ_RST;
    end else begin
      req_status <= req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global enable: a clear event beats a write of one in the same cycle
  always @* begin
    gie_nxt = global_irq_enable;
    if (gie_wr) begin
      gie_nxt = gie_wdata;
    end
    if (disable_irq_instruction) begin
      gie_nxt = 1'b0;
    end
    if (ack_taken) begin
      gie_nxt = 1'b0;
    end
    if (trap_any) begin
      gie_nxt = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      global_irq_enable <= 1'b0;
    end else begin
      global_irq_enable <= gie_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level decode on next state, so the registered outputs describe the state beside them
  // Watchdog source is forced to level 3; level 0 keeps a source out of the ranking
  genvar g;
  generate
    for (g = 0; g < `PIC_NSRC; g = g + 1) begin : g_lvl
      wire [`PIC_LVL_W-1:0] lv;
      assign lv = (g == `PIC_WDT_SRC) ? `PIC_LVL_3 : src_lvl_nxt[2*g+1:2*g];
      assign live[g] = req_nxt[g] & src_en_nxt[g];
      assign at_l3[g] = live[g] & (lv == `PIC_LVL_3);
      assign at_l2[g] = live[g] & (lv == `PIC_LVL_2);
      assign at_l1[g] = live[g] & (lv == `PIC_LVL_1);
    end
  endgenerate

  // One fixed ranking per level
  pic_pick u_pick3 (
    .cand(at_l3), // Level 3 candidates
    .found(f3), // Any at level 3
    .idx(i3) // Winner at level 3
  );
  pic_pick u_pick2 (
    .cand(at_l2), // Level 2 candidates
    .found(f2), // Any at level 2
    .idx(i2) // Winner at level 2
  );
  pic_pick u_pick1 (
    .cand(at_l1), // Level 1 candidates
    .found(f1), // Any at level 1
    .idx(i1) // Winner at level 1
  );

  // Higher level always wins regardless of source index
  assign idx_nxt = f3 ? i3 : (f2 ? i2 : i1);
  assign level_nxt = f3 ? `PIC_LVL_3 : (f2 ? `PIC_LVL_2 : (f1 ? `PIC_LVL_1 : `PIC_LVL_OFF));
  assign valid_nxt = gie_nxt & (f3 | f2 | f1);

  ////////////////////////////////////////////////////////////////////////////
  // Presented request, registered from next state so it changes with the state it shows
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_valid <= 1'b0;
      irq_idx <= {`PIC_IDX_W{1'b0}};
      irq_level <= `PIC_LVL_OFF;
    end else begin
      irq_valid <= valid_nxt;
      irq_idx <= idx_nxt;
      irq_level <= level_nxt;
    end
  end

endmodule // pic_ctrl

/* File: pic_map.vh */
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

// Source count and level encoding
`define PIC_NSRC 8
`define PIC_IDX_W 3
`define PIC_LVL_W 2
`define PIC_LVL_OFF 2'h0
`define PIC_LVL_1 2'h1
`define PIC_LVL_2 2'h2
`define PIC_LVL_3 2'h3
// Source index of the watchdog interrupt request
`define PIC_WDT_SRC 3'h0
// Trap cause codes
`define PIC_TRAP_W 3
`define PIC_TRAP_NONE 3'h0
`define PIC_TRAP_SW 3'h1
`define PIC_TRAP_ILLEGAL 3'h2
`define PIC_TRAP_OSC_FAIL 3'h3
`define PIC_TRAP_WDOSC_FAIL 3'h4
// Reset values
`define PIC_REQ_RST 8'h00
`define PIC_EN_RST 8'h00
`define PIC_LVL_RST 16'h0000

`endif

/* File: pic_pick.v */
`timescale 1ns/100ps
`include "pic_map.vh"

module pic_pick (
  input wire [`PIC_NSRC-1:0] cand, // Candidates at one level
  output reg found, // Any candidate present
  output reg [`PIC_IDX_W-1:0] idx // Lowest index wins
);

  integer i;

  // Fixed ranking: lower source index ranks higher
  always @* begin
    found = 1'b0;
    idx = {`PIC_IDX_W{1'b0}};
    for (i = `PIC_NSRC-1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        found = 1'b1;
        idx = i[`PIC_IDX_W-1:0];
      end
    end
  end

endmodule // pic_pick

/* File: pic_ctrl_assertions.sv */
`timescale 1ns/100ps
module pic_ctrl_assertions (
  input wire clk, // Clock
  input wire resetn, // Reset
  input wire [7:0] src_pulse, // Pulses
  input wire wdt_timeout, // Time-out
  input wire watchdog_reset_select, // Option
  input wire gie_wr, // Enable write
  input wire gie_wdata, // Enable data
  input wire disable_irq_instruction, // Disable
  input wire [2:0] trap_code, // Trap
  input wire req_wr, // Request write
  input wire [7:0] req_wdata, // Request data
  input wire irq_ack, // Ack
  input wire global_irq_enable, // Enable
  input wire [7:0] req_status, // Pending
  input wire irq_valid, // Presented
  input wire [2:0] irq_idx, // Winner
  input wire wdt_reset_req // Reset demand
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_gie_set: assert property (gie_wr && gie_wdata && !disable_irq_instruction && trap_code == 0
    && !(irq_ack && irq_valid) |=> global_irq_enable) else $error("enable not set");
  chk_gie_clr: assert property (disable_irq_instruction || trap_code != 0 || irq_ack && irq_valid
    |=> !global_irq_enable) else $error("enable not cleared");
  chk_pulse_kept: assert property (1 |=> (req_status & $past(src_pulse)) == $past(src_pulse))
    else $error("pulse lost");
  chk_ack_clears: assert property (irq_valid && irq_ack && src_pulse == 0 && !wdt_timeout
    |=> !req_status[$past(irq_idx)]) else $error("ack left request");
  chk_zero_write: assert property (req_wr && !irq_ack && !wdt_timeout |=> req_status ==
    ($past(req_status) & $past(req_wdata) | $past(src_pulse))) else $error("bad write");
  chk_none_off: assert property (!global_irq_enable |-> !irq_valid)
    else $error("presented while off");
  chk_valid_pending: assert property (irq_valid |-> req_status[irq_idx])
    else $error("presented request not pending");
  chk_wdt_reset: assert property (wdt_timeout && watchdog_reset_select |=> wdt_reset_req)
    else $error("no reset");
  chk_wdt_irq: assert property (wdt_timeout && !watchdog_reset_select
    |=> req_status[0] && !wdt_reset_req) else $error("no watchdog request");
endmodule // pic_ctrl_assertions
bind pic_ctrl pic_ctrl_assertions pic_ctrl_assertions_inst (.*);

/* File: pic_core_model.sv */
`timescale 1ns/100ps
module pic_core_model (
  input wire clk, // Clock
  input wire resetn, // Reset
  input wire irq_valid, // Presented
  input wire go, // Service allowed; held low to stall
  output reg irq_ack // One-cycle ack
);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) irq_ack <= 1'b0;
    else irq_ack <= irq_valid && go && !irq_ack;
  end
endmodule // pic_core_model

/* File: pic_ctrl_bench.sv */
`timescale 1ns/100ps
module pic_ctrl_bench;
  reg clk = 0, resetn = 0, wt = 0, ws = 0, gw = 0, gd = 0, di = 0, rw = 0, ew = 0, lw = 0, go = 0;
  reg [7:0] sp = 0, rd = 0, ed = 0;
  reg [15:0] ld = 0;
  reg [2:0] tc = 0;
  wire iv, ga, wr, ack;
  wire [7:0] rs;
  wire [2:0] ix;
  wire [1:0] il;
  integer miscompares = 0, comparisons = 0, cyc = 0, i;
  always #20 clk = ~clk;
  pic_ctrl pic_ctrl_inst (.clk(clk), .resetn(resetn), .src_pulse(sp), .wdt_timeout(wt),
    .watchdog_reset_select(ws), .gie_wr(gw), .gie_wdata(gd), .disable_irq_instruction(di),
    .trap_code(tc), .req_wr(rw), .req_wdata(rd), .en_wr(ew), .en_wdata(ed), .lvl_wr(lw),
    .lvl_wdata(ld), .irq_ack(ack), .global_irq_enable(ga), .req_status(rs), .irq_valid(iv),
    .irq_idx(ix), .irq_level(il), .wdt_reset_req(wr));
  pic_core_model pic_core_model_inst (.clk(clk), .resetn(resetn), .irq_valid(iv), .go(go),
    .irq_ack(ack));
  task chk(input [79:0] nm, input [15:0] s, input [15:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h saw %h", nm, e, s);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // Strobes last one edge; sampling at the next falling edge
  task hit;
    begin
      @(posedge clk);
      {gw, di, rw, ew, lw, wt, sp, tc} <= 0;
      @(negedge clk);
    end
  endtask
  task t_walk;
    begin
      @(posedge clk); {gw, gd, ew, lw} <= 4'hf; ed <= 8'hff; ld <= 16'h0080; hit;
      @(posedge clk); sp <= 8'h08; hit;
      chk("walk", {ga, rs, iv, ix, il}, {1'b1, 8'h08, 1'b1, 3'h3, 2'h2});
      @(posedge clk); go <= 1;
      for (i = 0; i < 8 && iv; i = i + 1) @(negedge clk);
      go <= 0;
      chk("ack", {ga, rs, iv}, 10'h000);
      $display("t_walk done");
    end
  endtask
  task t_prio;
    begin
      @(posedge clk); {gw, gd, lw} <= 3'h7; ld <= 16'h2834; sp <= 8'h66; hit;
      chk("lvl3", {ix, il}, {3'h2, 2'h3});
      @(posedge clk); rw <= 1; rd <= 8'hfb; hit;
      chk("tie", {rs, ix, il}, {8'h62, 3'h5, 2'h2});
      @(posedge clk); ew <= 1; ed <= 8'hdf; hit;
      chk("mask", {rs, ix}, {8'h62, 3'h6});
      @(posedge clk); rw <= 1; rd <= 8'h9f; hit;
      chk("lvl1", {ix, il}, {3'h1, 2'h1});
      @(posedge clk); rw <= 1; rd <= 8'h00; ew <= 1; ed <= 8'hff; hit;
      $display("t_prio done");
    end
  endtask
  task t_clear;
    integer k;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        @(posedge clk); gw <= 1; gd <= 1; hit;
        chk("set", ga, 1);
        @(posedge clk);
        if (k == 0) di <= 1;
        else if (k < 5) tc <= k[2:0];
        else {gw, gd} <= 2'h2;
        hit;
        chk("clear", ga, 0);
      end
      $display("t_clear done");
    end
  endtask
  task t_wdt;
    begin
      @(posedge clk); {gw, gd, lw} <= 3'h7; ld <= 16'h0001; wt <= 1; hit;
      chk("wdirq", {rs, ix, il, wr}, {8'h01, 3'h0, 2'h3, 1'b0});
      @(posedge clk); ws <= 1; wt <= 1; hit;
      chk("wdrst", wr, 1);
      $display("t_wdt done");
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    t_walk;
    t_prio;
    t_clear;
    t_wdt;
    report_and_stop;
  end
endmodule // pic_ctrl_bench
